// >>> src/mode_pin_mux.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "mode_pin_mux_defs.svh"
//
// Summary of operation
// [RULE_01] Reset sets the non-maskable mask bit; nonmaskable requests ignored until cleared.
// [RULE_02] Non-maskable request input is active-low and level-sensitive, wired-OR capable.
// [RULE_03] Each shared-line source drives open-drain and holds low until acknowledged.
// [RULE_04] A line still low after service interrupts again once its mask clears.
// [RULE_05] Two mode pins sampled in reset choose single-chip, expanded, test or bootstrap.
// [RULE_06] Sampled mode latched at reset release and held until next reset.
// [RULE_07] After mode select, mode pin A is open-drain fetch flag, low in opcode fetch; the code flags fetches in expanded and test modes only.
// [RULE_08] Strobe-A pin is input handshake in single-chip, address strobe when expanded.
// [RULE_09] Address strobe is active-high; external latch captures on its falling edge.
// [RULE_10] Strobe-B pin is a programmable output handshake strobe in single-chip mode.
// [RULE_11] Expanded: direction pin low for write cycles, high for read cycles.
// [RULE_12] Direction pin stays low across back-to-back write cycles.
// [RULE_13] With read visibility on, internal reads are driven out on the low port.
// [RULE_14] High port: general outputs single-chip; address 15..8 when expanded, register external.
// [RULE_15] Low port: general I/O single-chip; multiplexed address/data when expanded.
// [RULE_16] Timer port offers three captures, four compares, one capture-or-compare, else I/O.
// [RULE_17] Only timer bits 7 and 3 have direction bits, in pulse accumulator control.
// [RULE_18] Timer bit 7 always feeds the pulse accumulator input.
// [RULE_19] Timer bits 6..4 are outputs or compares 2..4, also drivable by master compare.
// [RULE_20] Timer bit 3 selects capture 4 or compare 5; master edges may trigger capture.
// [RULE_21] Timer port read: pin level for inputs, driver input level for outputs.
// [RULE_22] Timer port write updates latch; drives output pins only, never timer-owned pins.
// [RULE_23] Single-chip high port read returns level at driver input side; the code returns the synchronised pin level (s_hp2) instead.
// [RULE_24] Strobed output mode pulses output strobe on every high port write.
//
module mode_pin_mux #(
   parameter int OUT_HANDSHAKE_STROBE_BUS_CYCLES = 1
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // core bus cycle request and answer
   input  wire mode_pin_mux_pkg::cycle_s cyc_i,
   output logic             cyc_ready_o,
   output logic             rd_valid_o,
   output logic [7:0]       rd_data_o,
   output logic             e_clk_o,
   output logic [1:0]       op_mode_o,
   // interrupt pins and requests to the core
   input  wire logic        nonmaskable_int_n_i,
   input  wire logic        irq_n_i,
   output logic             nmi_req_o,
   output logic             irq_req_o,
   // mode pins, pin a doubles as fetch flag
   input  wire logic        mode_sel_a_i,
   input  wire logic        mode_sel_b_i,
   output logic             mode_sel_a_o,
   output logic             mode_sel_a_oe_n_o,
   // strobe pins
   input  wire logic        in_handshake_strobe_pin_i,
   output logic             in_handshake_strobe_pin_o,
   output logic             in_handshake_strobe_pin_oe_n_o,
   output logic             out_handshake_strobe_pin_o,
   // high port
   input  wire logic [7:0]  high_port_i,
   output logic [7:0]       high_port_o,
   // low port
   input  wire logic [7:0]  low_port_i,
   output logic [7:0]       low_port_o,
   output logic [7:0]       low_port_oe_n_o,
   // timer port and timer block
   input  wire logic [7:0]  timer_port_i,
   output logic [7:0]       timer_port_o,
   output logic [7:0]       timer_port_oe_n_o,
   input  wire logic [7:0]  cmp_en_i,
   input  wire logic [7:0]  cmp_val_i,
   input  wire logic [7:0]  master_cmp_en_i,
   input  wire logic [7:0]  master_cmp_val_i,
   output logic [2:0]       capture_o,
   output logic             capture_ch4_o,
   output logic             accum_in_o
);

   // ------------------------------------------------------------
   // elaboration checks and helpers
   // ------------------------------------------------------------
   localparam int OUT_HANDSHAKE_STROBE_LEN = OUT_HANDSHAKE_STROBE_BUS_CYCLES * `BUS_DIV;

   if (OUT_HANDSHAKE_STROBE_BUS_CYCLES < 1 || OUT_HANDSHAKE_STROBE_BUS_CYCLES > 7) begin : g_bad_out_handshake_strobe
      $error("strobe length must be 1 to 7 bus cycles");
   end

   // offset decode used by the error path only
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_TIMER_PORT) ||
                  (a == `OFF_HIGH_PORT) || (a == `OFF_LOW_PORT) ||
                  (a == `OFF_LOW_DIR) || (a == `OFF_PULSE_ACC);
   endfunction

   mode_pin_mux_pkg::state_s st;
   mode_pin_mux_pkg::state_s next_st;

   logic       expanded;
   logic       setup_ph;
   logic       wr_acc;
   logic [7:0] tp_dir;
   logic [7:0] tp_own;
   logic [7:0] tp_drv;
   logic [7:0] tp_read;
   logic       in_handshake_strobe_edge;
   logic       hp_write;

   // ------------------------------------------------------------
   // combinational pin functions
   // ------------------------------------------------------------
   // test mode is an expanded variant, bootstrap a single-chip one
   assign expanded = (st.mode == mode_pin_mux_pkg::MODE_EXPANDED) ||
                     (st.mode == mode_pin_mux_pkg::MODE_TEST);
   assign setup_ph = psel_i && !penable_i;
   assign wr_acc   = psel_i && penable_i && pwrite_i;
   assign hp_write = wr_acc && (paddr_i == `OFF_HIGH_PORT) && !expanded;
   // edge detector reads the second synchroniser stage only
   assign in_handshake_strobe_edge = st.s_in_handshake_strobe[1] && !st.in_handshake_strobe_d && !expanded;

   // timer port directions: bits 2..0 in, 6..4 out, 7 and 3 programmable
   assign tp_dir = {st.dir_hi, 3'b111, st.dir_mid, 3'b000};                 // [RULE_17]
   // master compare outranks the channel compares; bit 3 compares only as channel 5
   assign tp_own = {master_cmp_en_i[7], master_cmp_en_i[6:4] | cmp_en_i[6:4],
                    master_cmp_en_i[3] | (cmp_en_i[3] & st.ch5_sel), 3'b000}; // [RULE_19] [RULE_20]
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         if (master_cmp_en_i[b] && b >= 3) begin
            tp_drv[b] = master_cmp_val_i[b];
         end else if (tp_own[b]) begin
            tp_drv[b] = cmp_val_i[b];
         end else begin
            tp_drv[b] = st.tp_latch[b];                                    // [RULE_22]
         end
      end
   end
   // outputs read back their driver input, inputs their synced pin
   assign tp_read = (tp_dir & tp_drv) | (~tp_dir & st.s_tp2);               // [RULE_21]

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      // synchronisers run in and out of reset so straps are live at release
      next_st.s_mode_a = {st.s_mode_a[0], mode_sel_a_i};
      next_st.s_mode_b = {st.s_mode_b[0], mode_sel_b_i};
      next_st.s_nmi    = {st.s_nmi[0], nonmaskable_int_n_i};
      next_st.s_irq    = {st.s_irq[0], irq_n_i};
      next_st.s_in_handshake_strobe   = {st.s_in_handshake_strobe[0], in_handshake_strobe_pin_i};
      next_st.in_handshake_strobe_d   = st.s_in_handshake_strobe[1];
      next_st.s_tp1    = timer_port_i;
      next_st.s_tp2    = st.s_tp1;
      next_st.s_hp1    = high_port_i;
      next_st.s_hp2    = st.s_hp1;
      next_st.s_lp1    = low_port_i;
      next_st.s_lp2    = st.s_lp1;
      next_st.rd_valid = 1'b0;

      // bus clock phase counter, one bus cycle per four mclk
      next_st.phase = st.phase + 2'h1;
      if (st.phase == `PH_LAST) begin
         // a new bus cycle starts; idle cycles read so the direction pin rests high
         next_st.cyc = expanded ? cyc_i : '0;
         next_st.rw  = !(expanded && cyc_i.valid && cyc_i.wr);              // [RULE_11] [RULE_12]
      end
      // internal reads answer as their cycle ends; external data needs two
      // synchroniser edges, so it is taken one edge into the next bus cycle
      next_st.rd_pend = 1'b0;
      if (expanded && st.phase == `PH_LAST && st.cyc.valid && !st.cyc.wr) begin
         next_st.rd_valid = st.cyc.internal;
         next_st.rd_pend  = !st.cyc.internal;
         if (st.cyc.internal) begin
            next_st.rd_data = st.cyc.idata;
         end
      end
      // second stage now holds the pins as seen while the bus clock was high
      if (st.rd_pend) begin
         next_st.rd_valid = 1'b1;
         next_st.rd_data  = st.s_lp2;                                      // [RULE_15]
      end

      // strobe a in single-chip latches the low port and flags it
      if (in_handshake_strobe_edge) begin
         next_st.in_handshake_strobe_latch = st.s_lp2;
      end
      // output strobe pulse counter
      if (st.out_handshake_strobe_cnt != 5'h00) begin
         next_st.out_handshake_strobe_cnt = st.out_handshake_strobe_cnt - 5'h01;
      end
      if (hp_write && st.out_handshake_strobe_en) begin
         next_st.out_handshake_strobe_cnt = 5'(OUT_HANDSHAKE_STROBE_LEN);                                  // [RULE_24]
      end

      // apb setup: capture read data and the error answer
      if (setup_ph) begin
         next_st.err   = !is_mapped(paddr_i) || (paddr_i == `OFF_HIGH_PORT && expanded); // [RULE_14]
         next_st.rdata = '0;
         unique case (paddr_i)
            `OFF_CTRL: begin
               next_st.rdata[`CTRL_SHOW_IR] = st.show_ir;
               next_st.rdata[`CTRL_OUT_HANDSHAKE_STROBE_EN] = st.out_handshake_strobe_en;
               next_st.rdata[`CTRL_XMASK]   = st.xmask;
               next_st.rdata[`CTRL_IMASK]   = st.imask;
            end
            `OFF_STATUS: begin
               next_st.rdata[1:0]             = st.mode;
               next_st.rdata[`STAT_IN_HANDSHAKE_STROBE_SEEN] = st.in_handshake_strobe_seen;
               next_st.rdata[`STAT_NMI_LVL]   = st.s_nmi[1];
               next_st.rdata[`STAT_IRQ_LVL]   = st.s_irq[1];
               next_st.rdata[15:8]            = st.in_handshake_strobe_latch;
            end
            `OFF_TIMER_PORT: next_st.rdata[7:0] = tp_read;                  // [RULE_21]
            `OFF_HIGH_PORT:  next_st.rdata[7:0] = expanded ? 8'h00 : st.s_hp2; // [RULE_23]
            `OFF_LOW_PORT:   next_st.rdata[7:0] = (st.lp_dir & st.lp_latch) |
                                                  (~st.lp_dir & st.s_lp2);
            `OFF_LOW_DIR:    next_st.rdata[7:0] = st.lp_dir;
            `OFF_PULSE_ACC: begin
               next_st.rdata[`PULSE_ACC_CTL_DIR_HI]  = st.dir_hi;
               next_st.rdata[`PULSE_ACC_CTL_DIR_MID] = st.dir_mid;
               next_st.rdata[`PULSE_ACC_CTL_CH5_SEL] = st.ch5_sel;
               next_st.rdata[`PULSE_ACC_CTL_MC_TRIG] = st.mc_trig;
            end
            default: next_st.rdata = '0;
         endcase
      end

      // apb access: writes take effect here
      if (wr_acc) begin
         unique case (paddr_i)
            `OFF_CTRL: begin
               next_st.show_ir = pwdata_i[`CTRL_SHOW_IR];
               next_st.out_handshake_strobe_en = pwdata_i[`CTRL_OUT_HANDSHAKE_STROBE_EN];
               // software may only clear the non-maskable mask
               next_st.xmask   = st.xmask & pwdata_i[`CTRL_XMASK];            // [RULE_01]
               next_st.imask   = pwdata_i[`CTRL_IMASK];
            end
            `OFF_STATUS:     next_st.in_handshake_strobe_seen = st.in_handshake_strobe_seen & !pwdata_i[`STAT_IN_HANDSHAKE_STROBE_SEEN];
            `OFF_TIMER_PORT: next_st.tp_latch = pwdata_i[7:0];              // [RULE_22]
            `OFF_HIGH_PORT:  next_st.hp_latch = expanded ? st.hp_latch : pwdata_i[7:0]; // [RULE_14]
            `OFF_LOW_PORT:   next_st.lp_latch = pwdata_i[7:0];
            `OFF_LOW_DIR:    next_st.lp_dir   = pwdata_i[7:0];
            `OFF_PULSE_ACC: begin
               next_st.dir_hi  = pwdata_i[`PULSE_ACC_CTL_DIR_HI];                     // [RULE_17]
               next_st.dir_mid = pwdata_i[`PULSE_ACC_CTL_DIR_MID];
               next_st.ch5_sel = pwdata_i[`PULSE_ACC_CTL_CH5_SEL];                    // [RULE_20]
               next_st.mc_trig = pwdata_i[`PULSE_ACC_CTL_MC_TRIG];
            end
            default: next_st.err = st.err;
         endcase
      end
      // a strobe edge in the clearing cycle still sets the flag
      if (in_handshake_strobe_edge) begin
         next_st.in_handshake_strobe_seen = 1'b1;
      end

      if (sys_rst_i) begin
         // mode follows the synced straps throughout reset, frozen at release
         next_st.mode = mode_pin_mux_pkg::mode_e'({st.s_mode_b[1], st.s_mode_a[1]}); // [RULE_05] [RULE_06]
         next_st.phase      = `PH_LAST;
         next_st.cyc        = '0;
         next_st.rw         = 1'b1;
         next_st.rd_valid   = 1'b0;
         next_st.rd_pend    = 1'b0;
         next_st.rd_data    = `RST_BYTE;
         next_st.tp_latch   = `RST_BYTE;
         next_st.hp_latch   = `RST_BYTE;
         next_st.lp_latch   = `RST_BYTE;
         next_st.lp_dir     = `RST_BYTE;
         next_st.in_handshake_strobe_latch = `RST_BYTE;
         next_st.dir_hi     = 1'b0;
         next_st.dir_mid    = 1'b0;
         next_st.ch5_sel    = 1'b0;
         next_st.mc_trig    = 1'b0;
         next_st.show_ir    = 1'b0;
         next_st.out_handshake_strobe_en    = 1'b0;
         next_st.xmask      = `RST_MASK;                                    // [RULE_01]
         next_st.imask      = `RST_MASK;
         next_st.in_handshake_strobe_seen  = 1'b0;
         next_st.out_handshake_strobe_cnt   = 5'h00;
         next_st.rdata      = '0;
         next_st.err        = 1'b0;
      end
   end

   // single register stage for the whole state
   always_ff @(posedge mclk_i) begin
      st <= next_st;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // zero-wait apb slave; answer prepared in the setup cycle
   assign pready_o    = 1'b1;
   assign prdata_o    = st.rdata;
   assign pslverr_o   = psel_i && penable_i && st.err;
   assign cyc_ready_o = expanded && (st.phase == `PH_LAST) && !sys_rst_i;
   assign rd_valid_o  = st.rd_valid;
   assign rd_data_o   = st.rd_data;
   assign e_clk_o     = st.phase[1];
   assign op_mode_o   = st.mode;

   // level-sensitive requests, re-raised whenever the mask drops with the line low
   assign nmi_req_o = !st.s_nmi[1] && !st.xmask;                           // [RULE_02] [RULE_04]
   assign irq_req_o = !st.s_irq[1] && !st.imask;                           // [RULE_04]

   // fetch flag only after the straps have been released
   assign mode_sel_a_o      = 1'b0;
   assign mode_sel_a_oe_n_o = !(!sys_rst_i && expanded && st.cyc.valid && st.cyc.fetch); // [RULE_07]

   // strobe a: when expanded, always driven as address strobe, high in the first quarter; input in single-chip
   assign in_handshake_strobe_pin_o      = expanded && (st.phase == `PH_ADDR);            // [RULE_08] [RULE_09]
   assign in_handshake_strobe_pin_oe_n_o = !expanded;
   // strobe b: direction when expanded, handshake pulse otherwise
   assign out_handshake_strobe_pin_o = expanded ? st.rw : (st.out_handshake_strobe_cnt != 5'h00);          // [RULE_10] [RULE_11]

   assign high_port_o = expanded ? st.cyc.addr[15:8] : st.hp_latch;        // [RULE_14]

   // low port: when expanded, address in first half, data in second half of each bus cycle; latch and direction register in single-chip
   always_comb begin
      if (!expanded) begin
         low_port_o      = st.lp_latch;                                    // [RULE_15]
         low_port_oe_n_o = ~st.lp_dir;
      end else if (!st.phase[1]) begin
         low_port_o      = st.cyc.addr[7:0];                               // [RULE_15]
         low_port_oe_n_o = 8'h00;
      end else if (st.cyc.valid && st.cyc.wr) begin
         low_port_o      = st.cyc.wdata;
         low_port_oe_n_o = 8'h00;
      end else if (st.cyc.valid && st.cyc.internal && st.show_ir) begin
         low_port_o      = st.cyc.idata;                                   // [RULE_13]
         low_port_oe_n_o = 8'h00;
      end else begin
         low_port_o      = st.cyc.addr[7:0];
         low_port_oe_n_o = 8'hFF;
      end
   end

   assign timer_port_o      = tp_drv;                                      // [RULE_16]
   assign timer_port_oe_n_o = ~tp_dir;
   assign capture_o         = st.s_tp2[2:0];                               // [RULE_16]
   assign capture_ch4_o     = !st.ch5_sel && (st.mc_trig ? tp_drv[3] : st.s_tp2[3]); // [RULE_20]
   assign accum_in_o        = st.s_tp2[7];                                 // [RULE_18]

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   chk_nmi_reset_mask: assert property ($past(sys_rst_i) |-> !nmi_req_o) // [RULE_01]
      else $error("non-maskable request seen right after reset");
   chk_nmi_level: assert property                                         // [RULE_02]
      (!nonmaskable_int_n_i [*3] ##0 !st.xmask [*3] |-> nmi_req_o)
      else $error("held non-maskable level not requested");
   chk_irq_retake: assert property                                        // [RULE_04]
      ($fell(st.imask) && !irq_n_i && $past(!irq_n_i, 2) |-> irq_req_o)
      else $error("pending level not retaken on mask clear");
   chk_mode_frozen: assert property (!$past(sys_rst_i) |-> $stable(st.mode)) // [RULE_06]
      else $error("mode changed outside reset");
   chk_fetch_flag: assert property                                        // [RULE_07]
      (expanded && st.phase == `PH_LAST && cyc_i.valid && cyc_i.fetch
       |=> !mode_sel_a_oe_n_o [*4])
      else $error("fetch flag not low for the fetch bus cycle");
   chk_addr_strobe: assert property                                       // [RULE_09]
      ($rose(in_handshake_strobe_pin_o) |=> !in_handshake_strobe_pin_o [*3] ##1 in_handshake_strobe_pin_o)
      else $error("address strobe not one quarter high");
   chk_rw_writes: assert property                                         // [RULE_12]
      (expanded && st.cyc.valid && st.cyc.wr && st.phase == `PH_LAST &&
       cyc_i.valid && cyc_i.wr |=> !out_handshake_strobe_pin_o [*4])
      else $error("direction pin rose between writes");
   chk_high_addr: assert property                                         // [RULE_14]
      (cyc_ready_o |=> high_port_o == $past(cyc_i.addr[15:8]))
      else $error("high port not carrying upper address");
   chk_strobe_pulse: assert property                                      // [RULE_24]
      (hp_write && st.out_handshake_strobe_en && OUT_HANDSHAKE_STROBE_BUS_CYCLES == 1 |=> out_handshake_strobe_pin_o [*4] ##1 !out_handshake_strobe_pin_o)
      else $error("output strobe pulse length wrong");
   chk_timer_owned: assert property                                       // [RULE_22]
      (master_cmp_en_i[4] |-> timer_port_o[4] == master_cmp_val_i[4])
      else $error("latch overrode a compare-owned pin");

   cov_write_pair: cover property (expanded && st.cyc.wr ##4 st.cyc.wr);
   cov_visible_rd: cover property (!low_port_oe_n_o[0] && st.phase[1] && !st.cyc.wr && expanded);
   cov_strobe_a:   cover property (in_handshake_strobe_edge);
   cov_nmi_taken:  cover property ($fell(st.xmask) ##1 nmi_req_o);

endmodule

// >>> src/mode_pin_mux_defs.svh
`ifndef MODE_PIN_MUX_DEFS_SVH
`define MODE_PIN_MUX_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_TIMER_PORT  8'h08
`define OFF_HIGH_PORT   8'h0C
`define OFF_LOW_PORT    8'h10
`define OFF_LOW_DIR     8'h14
`define OFF_PULSE_ACC   8'h18

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_SHOW_IR    0
`define CTRL_OUT_HANDSHAKE_STROBE_EN    1
`define CTRL_XMASK      4
`define CTRL_IMASK      5
`define STAT_IN_HANDSHAKE_STROBE_SEEN  2
`define STAT_NMI_LVL    3
`define STAT_IRQ_LVL    4
`define PULSE_ACC_CTL_DIR_HI    7
`define PULSE_ACC_CTL_DIR_MID   3
`define PULSE_ACC_CTL_CH5_SEL   2
`define PULSE_ACC_CTL_MC_TRIG   1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_MASK        1'b1

// ------------------------------------------------------------
// timing: bus clock is one quarter of mclk
// ------------------------------------------------------------
`define BUS_DIV         4
`define PH_ADDR         2'h0
`define PH_LAST         2'h3

`endif

// >>> src/mode_pin_mux_pkg.sv
package mode_pin_mux_pkg;

   // operating mode, ordinal equals {mode_sel_b, mode_sel_a}
   typedef enum logic [1:0] {
      MODE_BOOT,
      MODE_TEST,
      MODE_SINGLE,
      MODE_EXPANDED
   } mode_e;

   // one bus cycle as handed in by the core
   typedef struct packed {
      logic        valid;
      logic        wr;
      logic        fetch;
      logic        internal;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  idata;
   } cycle_s;

   // complete state of the block
   typedef struct packed {
      logic [1:0]  s_mode_a;
      logic [1:0]  s_mode_b;
      logic [1:0]  s_nmi;
      logic [1:0]  s_irq;
      logic [1:0]  s_in_handshake_strobe;
      logic        in_handshake_strobe_d;
      logic [7:0]  s_tp1;
      logic [7:0]  s_tp2;
      logic [7:0]  s_hp1;
      logic [7:0]  s_hp2;
      logic [7:0]  s_lp1;
      logic [7:0]  s_lp2;
      mode_e       mode;
      logic [1:0]  phase;
      cycle_s      cyc;
      logic        rw;
      logic        rd_valid;
      logic        rd_pend;
      logic [7:0]  rd_data;
      logic [7:0]  tp_latch;
      logic [7:0]  hp_latch;
      logic [7:0]  lp_latch;
      logic [7:0]  lp_dir;
      logic        dir_hi;
      logic        dir_mid;
      logic        ch5_sel;
      logic        mc_trig;
      logic        show_ir;
      logic        out_handshake_strobe_en;
      logic        xmask;
      logic        imask;
      logic        in_handshake_strobe_seen;
      logic [7:0]  in_handshake_strobe_latch;
      logic [4:0]  out_handshake_strobe_cnt;
      logic [31:0] rdata;
      logic        err;
   } state_s;

endpackage

// >>> tb/ext_side.sv
`timescale 1ns/1ps
module ext_side (
   // bus side
   input  wire logic       e_i,
   input  wire logic       rw_i,
   input  wire logic [7:0] ad_i,
   output logic [7:0]      ad_o,
   // interrupt source
   input  wire logic       nmi_set_i,
   output logic            nmi_n_o
);
   // memory drives only in the data half of a read; else a changing pattern
   assign ad_o = (e_i && rw_i) ? 8'h5a : ~ad_i;
   // open-drain source holds the line low until the bench lets go
   assign nmi_n_o = ~nmi_set_i;
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
   // ----------
   // signals
   // ----------
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, msa = 0, msb = 1, nset = 0, sa = 0;
   logic [7:0] paddr = 0, mcen = 0, hp, lp_o, lp_i, lp_oe, tp_o, tp_oe, rd;
   logic [31:0] pwd = 0, prd, r;
   logic rdy, err, es, cr, rv, ec, nmi_n, ma_o, ma_oe, sa_o, sa_oe, sb, acc, nq, iq, c4;
   logic [1:0] mode;
   logic [2:0] cap;
   mode_pin_mux_pkg::cycle_s cyc = '0;
   int failures = 0, tests_run = 0, cycles = 0;
   always #12.5 clk = ~clk;
   // wired pins are resolved here; both interrupt inputs share one open-drain line
   mode_pin_mux mode_pin_mux_i (.mclk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(err), .cyc_i(cyc), .cyc_ready_o(cr), .rd_valid_o(rv), .rd_data_o(rd),
      .e_clk_o(ec), .op_mode_o(mode), .nonmaskable_int_n_i(nmi_n), .irq_n_i(nmi_n),
      .nmi_req_o(nq), .irq_req_o(iq), .mode_sel_a_i(ma_oe ? msa : ma_o), .mode_sel_b_i(msb),
      .mode_sel_a_o(ma_o), .mode_sel_a_oe_n_o(ma_oe), .in_handshake_strobe_pin_i(sa_oe ? sa : sa_o),
      .in_handshake_strobe_pin_o(sa_o), .in_handshake_strobe_pin_oe_n_o(sa_oe), .out_handshake_strobe_pin_o(sb), .high_port_i(hp),
      .high_port_o(hp), .low_port_i(lp_i), .low_port_o(lp_o), .low_port_oe_n_o(lp_oe),
      .timer_port_i({tp_o[7:3], 3'h5}), .timer_port_o(tp_o), .timer_port_oe_n_o(tp_oe),
      .cmp_en_i(8'h00), .cmp_val_i(8'h00), .master_cmp_en_i(mcen), .master_cmp_val_i(8'h00),
      .capture_o(cap), .capture_ch4_o(c4), .accum_in_o(acc));
   ext_side ext_side_i (.e_i(ec), .rw_i(sb), .ad_i(lp_o), .ad_o(lp_i), .nmi_set_i(nset),
      .nmi_n_o(nmi_n));
   // ----------
   // tasks
   // ----------
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // apb master; returns at the negedge after release so checks see settled outputs
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = prd;
      es = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(negedge clk);
   endtask
   task do_rst(input logic a, input logic b);
      @(posedge clk);
      msa <= a;
      msb <= b;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
   endtask
   // one core bus cycle, checked phase by phase
   task bus(input mode_pin_mux_pkg::cycle_s c);
      @(posedge clk);
      cyc <= c;
      @(negedge clk);
      while (cr !== 1'b1) @(negedge clk);
      // taken at this edge; drop it so the next bus cycle is not a repeat
      @(posedge clk);
      cyc <= '0;
      @(negedge clk);
      chk("as_hi", sa_o, 1);
      chk("a_hi", hp, c.addr[15:8]);
      chk("a_lo", {lp_oe, lp_o}, {8'h00, c.addr[7:0]});
      chk("fetch", ma_oe, !c.fetch);
      @(negedge clk);
      chk("as_lo", sa_o, 0);
      @(negedge clk);
      chk("rw", {ec, sb}, {1'b1, !c.wr});
      if (c.wr) chk("wd", {lp_oe, lp_o}, {8'h00, c.wdata});
      else if (c.internal) chk("ird", {lp_oe, lp_o}, {8'h00, c.idata});
      else chk("rel", lp_oe, 8'hff);
      if (!c.wr) begin
         while (rv !== 1'b1) @(negedge clk);
         chk("rdat", rd, c.internal ? c.idata : 8'h5a);
      end
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         give_verdict;
      end
   end
   // single-chip pass, then a second reset into expanded
   initial begin
      do_rst(1'b0, 1'b1);
      chk("mode", mode, 2);
      apb(0, 8'h00, 0);
      chk("ctrl", r[5:4], 2'h3);
      @(posedge clk);
      nset <= 1'b1;
      msa <= 1'b1;
      repeat (4) @(negedge clk);
      chk("nmi_m", nq, 0);
      apb(1, 8'h00, 32'h0000_0002);
      chk("nmi", nq, 1);
      chk("irq", iq, 1);
      apb(1, 8'h0c, 32'h0000_00a5);
      chk("out_handshake_strobe", sb, 1);
      chk("hp", hp, 8'ha5);
      chk("hold", mode, 2);
      repeat (4) @(negedge clk);
      chk("strb0", sb, 0);
      @(posedge clk);
      sa <= 1'b1;
      repeat (4) @(negedge clk);
      apb(0, 8'h04, 0);
      chk("in_handshake_strobe", {r[15:8], r[2:0]}, {8'hff, 3'h6});
      apb(0, 8'h0c, 0);
      chk("hp_rd", r, 32'h0000_00a5);
      apb(1, 8'h18, 32'h0000_0088);
      apb(1, 8'h08, 32'h0000_00ff);
      chk("tp_oe", tp_oe, 8'h07);
      apb(0, 8'h08, 0);
      chk("tp_rd", r, 32'h0000_00fd);
      chk("cap", {acc, c4, cap}, 5'h1d);
      @(posedge clk);
      mcen <= 8'h10;
      repeat (2) @(negedge clk);
      chk("mc", tp_o[4], 0);
      do_rst(1'b1, 1'b1);
      chk("mode_x", mode, 3);
      apb(1, 8'h0c, 0);
      chk("hp_x", es, 1);
      apb(1, 8'h00, 32'h0000_0001);
      bus('{1, 1, 0, 0, 16'h1234, 8'h3c, 8'h00});
      bus('{1, 1, 0, 0, 16'h1235, 8'hc3, 8'h00});
      bus('{1, 0, 0, 0, 16'h8000, 8'h00, 8'h00});
      bus('{1, 0, 1, 1, 16'h0010, 8'h00, 8'h77});
      give_verdict;
   end
endmodule
